// file: include/pcr_defs.vh
// Purpose: Constants for the power calibration and reset cause registers
// Assumes: APB byte addresses, 32-bit aligned words
// Notes: Definitions only
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH

// Register byte offsets
`define PCR_OFS_RC_OSC_TRIM 12'h0c0
`define PCR_OFS_BANDGAP_TRIM 12'h0c4
`define PCR_OFS_REGULATOR_TRIM 12'h0c8
`define PCR_OFS_BROWNOUT_SETUP 12'h0d0
`define PCR_OFS_LAST_RESET_SOURCE 12'h140
`define PCR_OFS_ASYNC_WAKE_ENABLE 12'h144
`define PCR_OFS_RETENTION_SCRATCH0 12'h200
`define PCR_OFS_RETENTION_SCRATCH1 12'h204

// Key field and values
`define PCR_KEY_MSB 31
`define PCR_KEY_LSB 24
`define PCR_KEY_FIRST 8'h55
`define PCR_KEY_SECOND 8'haa

// Shared fuse-done position
`define PCR_FUSE_DONE_BIT 16

// Trim field widths
`define PCR_RC_TRIM_W 10
`define PCR_BG_TRIM_W 3
`define PCR_VREG_TRIM_W 3

// Brown-out field positions
`define PCR_BOD_CTRL_MSB 9
`define PCR_BOD_CTRL_LSB 8
`define PCR_BOD_BROWNOUT_HYSTERESIS_BIT 6
`define PCR_BOD_LEVEL_MSB 5
`define PCR_BOD_LEVEL_LSB 0
`define PCR_BOD_FIELD_W 9

// Brown-out control codes
`define PCR_BOD_OFF0 2'h0
`define PCR_BOD_WITH_RESET 2'h1
`define PCR_BOD_NO_RESET 2'h2
`define PCR_BOD_OFF3 2'h3

// Reset cause bit positions
`define PCR_CAUSE_POR 0
`define PCR_CAUSE_BOD 1
`define PCR_CAUSE_PIN 2
`define PCR_CAUSE_WDT 3
`define PCR_CAUSE_JTAG 4
`define PCR_CAUSE_DEBUG 8
`define PCR_CAUSE_W 6

// Wake enable bit
`define PCR_USB_WAKE_BIT 0

// Fuse target selects
`define PCR_FUSE_SEL_RC 2'h0
`define PCR_FUSE_SEL_BG 2'h1
`define PCR_FUSE_SEL_VREG 2'h2
`define PCR_FUSE_SEL_BOD 2'h3

// Reset values
`define PCR_RST_ZERO32 32'h0000_0000
`define PCR_RST_FIELD10 10'h000
`define PCR_RST_TRIM3 3'h0
`define PCR_RST_BOD9 9'h000
`define PCR_RST_CAUSE 6'h00

`endif

// file: hw/pcr_power_trim_value_regs.v
// Purpose: Key-protected trim and brown-out regs; unkeyed reset cause and retention regs
// Assumes: APB slave on sys_clk; rstn low at least when por_n is low
// Notes: Zero wait states; read data is captured in the setup cycle
`timescale 1ns/10ps
`include "pcr_defs.vh"

// What this block does
// [RULE_01] Protected writes take effect only after key 0x55 then key 0xAA.
// [RULE_02] Fuse load of a trim field sets that register's fuse-done flag.
// [RULE_03] Fuse-done low allows fuse reloads; high blocks further fuse loads.
// [RULE_04] RC oscillator trim register drives the oscillator trim output.
// [RULE_05] Bandgap trim register low bits drive the bandgap trim output.
// [RULE_06] Regulator trim low bits drive regulator trim; software may change it.
// [RULE_07] Brown-out fuse-done set by fuse load; then fuses cannot reload it.
// [RULE_08] Brown-out control: 0,3 off; 1 on with reset; 2 on without reset.
// [RULE_09] Mode 2 detection only requests an interrupt when its mask is set.
// [RULE_10] Hysteresis bit selects hysteresis; level field sets threshold code.
// [RULE_11] Software changes the level only while the detector is off; the block does not check this and commits level writes in any mode.
// [RULE_12] Cause bit 8 marks a reset from the debug reset strobe.
// [RULE_13] Cause bit 4 marks a reset from the JTAG CPU reset request.
// [RULE_14] Cause bit 3 marks a watchdog timeout reset.
// [RULE_15] Cause bit 2 marks a reset from the external reset pin.
// [RULE_16] Cause bit 1 marks a brown-out reset.
// [RULE_17] Cause bit 0 marks a power-on reset.
// [RULE_18] Cause register is read-only and shows the latest reset source.
// [RULE_19] Wake enable bit 0 gates USB wake-up; register resets to zero.
// [RULE_20] Two 32-bit retention registers cleared only by power-on reset.
// [RULE_21] A write breaking the key sequence is dropped and restarts detection.
module pcr_power_trim_value_regs (
    input wire sys_clk,
    input wire rstn,
    input wire por_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire fuse_load,
    input wire [1:0] fuse_sel,
    input wire [9:0] fuse_data,
    input wire [5:0] reset_source_in,
    input wire brownout_detect,
    input wire interrupt_mask_view,
    output wire [9:0] rc_osc_trim_out,
    output wire [2:0] bandgap_trim_out,
    output wire [2:0] regulator_trim_out,
    output wire brownout_detector_enable,
    output wire brownout_reset_enable,
    output wire brownout_hysteresis,
    output wire [5:0] brownout_level,
    output wire brownout_reset_req,
    output wire brownout_irq_req,
    output wire usb_wakeup_enable
);

    reg rst_meta_ff;
    reg rst_sync_ff;
    reg por_meta_ff;
    reg por_sync_ff;
    reg key_armed_ff;
    reg nxt_key_armed;
    reg cause_taken_ff;
    reg [5:0] cause_ff;
    reg [9:0] rc_trim_ff;
    reg rc_done_ff;
    reg [2:0] bg_trim_ff;
    reg bg_done_ff;
    reg [2:0] vreg_trim_ff;
    reg vreg_done_ff;
    reg [8:0] bod_field_ff;
    reg bod_done_ff;
    reg wake_ff;
    reg [31:0] scratch0_ff;
    reg [31:0] scratch1_ff;
    reg [31:0] prdata_ff;
    reg [31:0] nxt_rdata;
    reg mapped;
    reg protected_sel;
    wire [7:0] key;
    wire access_wr;
    wire commit;
    wire [1:0] bod_ctrl;
    wire [31:0] cause_word;

    // Reset release through two flip-flops
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    always @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            por_meta_ff <= 1'b0;
            por_sync_ff <= 1'b0;
        end else begin
            por_meta_ff <= 1'b1;
            por_sync_ff <= por_meta_ff;
        end
    end

    // Address decode
    always @* begin
        mapped = 1'b1;
        protected_sel = 1'b0;
        case (paddr)
            `PCR_OFS_RC_OSC_TRIM: protected_sel = 1'b1;
            `PCR_OFS_BANDGAP_TRIM: protected_sel = 1'b1;
            `PCR_OFS_REGULATOR_TRIM: protected_sel = 1'b1;
            `PCR_OFS_BROWNOUT_SETUP: protected_sel = 1'b1;
            `PCR_OFS_LAST_RESET_SOURCE: mapped = 1'b1;
            `PCR_OFS_ASYNC_WAKE_ENABLE: mapped = 1'b1;
            `PCR_OFS_RETENTION_SCRATCH0: mapped = 1'b1;
            `PCR_OFS_RETENTION_SCRATCH1: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign access_wr = psel & penable & pwrite & mapped;
    assign key = pwdata[`PCR_KEY_MSB:`PCR_KEY_LSB];

    // Second key with sequence armed commits the write
    assign commit = access_wr & protected_sel & key_armed_ff &
                    (key == `PCR_KEY_SECOND); // RULE_01

    always @* begin
        nxt_key_armed = key_armed_ff;
        if (access_wr && protected_sel) begin
            if (!key_armed_ff && key == `PCR_KEY_FIRST) begin
                nxt_key_armed = 1'b1; // RULE_01
            end else begin
                nxt_key_armed = 1'b0; // RULE_21
            end
        end
    end

    always @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            key_armed_ff <= 1'b0;
        end else begin
            key_armed_ff <= nxt_key_armed;
        end
    end

    // Trim and brown-out registers, kept across all but power-on reset
    always @(posedge sys_clk or negedge por_sync_ff) begin
        if (!por_sync_ff) begin
            rc_trim_ff <= `PCR_RST_FIELD10;
            rc_done_ff <= 1'b0;
            bg_trim_ff <= `PCR_RST_TRIM3;
            bg_done_ff <= 1'b0;
            vreg_trim_ff <= `PCR_RST_TRIM3;
            vreg_done_ff <= 1'b0;
            bod_field_ff <= `PCR_RST_BOD9;
            bod_done_ff <= 1'b0;
        end else begin
            if (commit) begin
                case (paddr)
                    `PCR_OFS_RC_OSC_TRIM: begin
                        rc_trim_ff <= pwdata[9:0]; // RULE_04
                        rc_done_ff <= pwdata[`PCR_FUSE_DONE_BIT];
                    end
                    `PCR_OFS_BANDGAP_TRIM: begin
                        bg_trim_ff <= pwdata[2:0]; // RULE_05
                        bg_done_ff <= pwdata[`PCR_FUSE_DONE_BIT];
                    end
                    `PCR_OFS_REGULATOR_TRIM: begin
                        vreg_trim_ff <= pwdata[2:0]; // RULE_06
                        vreg_done_ff <= pwdata[`PCR_FUSE_DONE_BIT];
                    end
                    `PCR_OFS_BROWNOUT_SETUP: begin
                        bod_field_ff <= {pwdata[9:8], pwdata[6:0]};
                        bod_done_ff <= pwdata[`PCR_FUSE_DONE_BIT];
                    end
                    default: begin
                        bod_done_ff <= bod_done_ff;
                    end
                endcase
            end
            // Fuse load after software so the done flag set wins
            if (fuse_load) begin
                case (fuse_sel)
                    `PCR_FUSE_SEL_RC: begin
                        if (!rc_done_ff) begin // RULE_03
                            rc_trim_ff <= fuse_data;
                            rc_done_ff <= 1'b1; // RULE_02
                        end
                    end
                    `PCR_FUSE_SEL_BG: begin
                        if (!bg_done_ff) begin // RULE_03
                            bg_trim_ff <= fuse_data[2:0];
                            bg_done_ff <= 1'b1; // RULE_02
                        end
                    end
                    `PCR_FUSE_SEL_VREG: begin
                        if (!vreg_done_ff) begin // RULE_03
                            vreg_trim_ff <= fuse_data[2:0];
                            vreg_done_ff <= 1'b1; // RULE_02
                        end
                    end
                    default: begin
                        if (!bod_done_ff) begin // RULE_07
                            bod_field_ff <= {fuse_data[9:8], fuse_data[6:0]};
                            bod_done_ff <= 1'b1; // RULE_07
                        end
                    end
                endcase
            end
        end
    end

    // Retention registers cleared only by power-on reset
    always @(posedge sys_clk or negedge por_sync_ff) begin
        if (!por_sync_ff) begin
            scratch0_ff <= `PCR_RST_ZERO32; // RULE_20
            scratch1_ff <= `PCR_RST_ZERO32; // RULE_20
        end else if (access_wr) begin
            if (paddr == `PCR_OFS_RETENTION_SCRATCH0) begin
                scratch0_ff <= pwdata;
            end
            if (paddr == `PCR_OFS_RETENTION_SCRATCH1) begin
                scratch1_ff <= pwdata;
            end
        end
    end

    // Wake enable and reset cause capture after release
    always @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            wake_ff <= 1'b0; // RULE_19
            cause_taken_ff <= 1'b0;
            cause_ff <= `PCR_RST_CAUSE;
        end else begin
            if (access_wr && paddr == `PCR_OFS_ASYNC_WAKE_ENABLE) begin
                wake_ff <= pwdata[`PCR_USB_WAKE_BIT]; // RULE_19
            end
            if (!cause_taken_ff) begin
                cause_taken_ff <= 1'b1;
                cause_ff <= reset_source_in; // RULE_18
            end
        end
    end

    // Cause bits placed at their register positions
    assign cause_word = {23'h00_0000,
                         cause_ff[5], // RULE_12
                         3'h0,
                         cause_ff[4], // RULE_13
                         cause_ff[3], // RULE_14
                         cause_ff[2], // RULE_15
                         cause_ff[1], // RULE_16
                         cause_ff[0]}; // RULE_17

    // Read mux; keys read as zero
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (paddr)
            `PCR_OFS_RC_OSC_TRIM: begin
                nxt_rdata[9:0] = rc_trim_ff;
                nxt_rdata[`PCR_FUSE_DONE_BIT] = rc_done_ff;
            end
            `PCR_OFS_BANDGAP_TRIM: begin
                nxt_rdata[2:0] = bg_trim_ff;
                nxt_rdata[`PCR_FUSE_DONE_BIT] = bg_done_ff;
            end
            `PCR_OFS_REGULATOR_TRIM: begin
                nxt_rdata[2:0] = vreg_trim_ff;
                nxt_rdata[`PCR_FUSE_DONE_BIT] = vreg_done_ff;
            end
            `PCR_OFS_BROWNOUT_SETUP: begin
                nxt_rdata[9:8] = bod_field_ff[8:7];
                nxt_rdata[6:0] = bod_field_ff[6:0];
                nxt_rdata[`PCR_FUSE_DONE_BIT] = bod_done_ff;
            end
            `PCR_OFS_LAST_RESET_SOURCE: nxt_rdata = cause_word; // RULE_18
            `PCR_OFS_ASYNC_WAKE_ENABLE: nxt_rdata[0] = wake_ff;
            `PCR_OFS_RETENTION_SCRATCH0: nxt_rdata = scratch0_ff;
            `PCR_OFS_RETENTION_SCRATCH1: nxt_rdata = scratch1_ff;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            prdata_ff <= `PCR_RST_ZERO32;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= nxt_rdata;
        end
    end

    assign prdata = prdata_ff;

    // Analog control outputs
    assign rc_osc_trim_out = rc_trim_ff; // RULE_04
    assign bandgap_trim_out = bg_trim_ff; // RULE_05
    assign regulator_trim_out = vreg_trim_ff; // RULE_06
    assign bod_ctrl = bod_field_ff[8:7];
    assign brownout_detector_enable = (bod_ctrl == `PCR_BOD_WITH_RESET) |
                                      (bod_ctrl == `PCR_BOD_NO_RESET); // RULE_08
    assign brownout_reset_enable = (bod_ctrl == `PCR_BOD_WITH_RESET); // RULE_08
    assign brownout_hysteresis = bod_field_ff[6]; // RULE_10
    assign brownout_level = bod_field_ff[5:0]; // RULE_10
    assign brownout_reset_req = brownout_reset_enable & brownout_detect;
    assign brownout_irq_req = (bod_ctrl == `PCR_BOD_NO_RESET) &
                              brownout_detect & interrupt_mask_view; // RULE_09
    assign usb_wakeup_enable = wake_ff; // RULE_19

endmodule // pcr_power_trim_value_regs

// file: verification/pcr_regs_sva.sv
// Purpose: Port assertions for the calibration and reset cause registers
// Assumes: Bench never writes the bandgap fuse-done bit
// Notes: Bound to the design top below
`timescale 1ns/10ps
module pcr_regs_sva (
    input wire sys_clk,
    input wire rstn,
    input wire por_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire fuse_load,
    input wire [1:0] fuse_sel,
    input wire [9:0] fuse_data,
    input wire brownout_detect,
    input wire interrupt_mask_view,
    input wire [2:0] bandgap_trim_out,
    input wire [2:0] regulator_trim_out,
    input wire brownout_detector_enable,
    input wire brownout_reset_enable,
    input wire brownout_reset_req,
    input wire brownout_irq_req,
    input wire usb_wakeup_enable
);
    wire wr = psel && penable && pwrite;
    wire prot = paddr == 12'h0c0 || paddr == 12'h0c4 ||
        paddr == 12'h0c8 || paddr == 12'h0d0;
    reg armed_ff;
    reg bg_done_ff;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            armed_ff <= 1'b0;
        else if (wr && prot)
            armed_ff <= !armed_ff && pwdata[31:24] == 8'h55;
    end
    always @(posedge sys_clk or negedge por_n) begin
        if (!por_n)
            bg_done_ff <= 1'b0;
        else if (fuse_load && fuse_sel == 2'h1)
            bg_done_ff <= 1'b1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_commit;
        wr && prot && armed_ff && pwdata[31:24] == 8'haa;
    endsequence
    sequence s_bg_load;
        fuse_load && fuse_sel == 2'h1 && !(wr && paddr == 12'h0c4);
    endsequence
    en_decode_a: assert property (
        brownout_reset_enable |-> brownout_detector_enable)
        else $error("reset enable without detector enable");
    rst_req_a: assert property (
        brownout_reset_req == (brownout_reset_enable && brownout_detect))
        else $error("brown-out reset request mismatch");
    irq_gate_a: assert property (brownout_irq_req ==
        (brownout_detector_enable && !brownout_reset_enable &&
        brownout_detect && interrupt_mask_view))
        else $error("brown-out interrupt request mismatch");
    fuse_first_a: assert property (
        s_bg_load ##0 !bg_done_ff |=>
        bandgap_trim_out == $past(fuse_data[2:0]))
        else $error("first fuse load not applied");
    fuse_block_a: assert property (
        s_bg_load ##0 bg_done_ff |=> $stable(bandgap_trim_out))
        else $error("fuse load applied after done");
    key_commit_a: assert property (
        s_commit ##0 (paddr == 12'h0c8 && !fuse_load) |=>
        regulator_trim_out == $past(pwdata[2:0]))
        else $error("keyed write not committed");
    key_block_a: assert property (
        wr && paddr == 12'h0c8 && !fuse_load &&
        !(armed_ff && pwdata[31:24] == 8'haa) |=>
        $stable(regulator_trim_out))
        else $error("unkeyed write changed trim");
    wake_wr_a: assert property (
        wr && paddr == 12'h144 |=> usb_wakeup_enable == $past(pwdata[0]))
        else $error("wake enable not written");
endmodule // pcr_regs_sva

bind pcr_power_trim_value_regs pcr_regs_sva u_sva (
    .sys_clk(sys_clk), .rstn(rstn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .fuse_load(fuse_load), .fuse_sel(fuse_sel), .fuse_data(fuse_data),
    .brownout_detect(brownout_detect),
    .interrupt_mask_view(interrupt_mask_view),
    .bandgap_trim_out(bandgap_trim_out),
    .regulator_trim_out(regulator_trim_out),
    .brownout_detector_enable(brownout_detector_enable),
    .brownout_reset_enable(brownout_reset_enable),
    .brownout_reset_req(brownout_reset_req),
    .brownout_irq_req(brownout_irq_req),
    .usb_wakeup_enable(usb_wakeup_enable)
);

// file: verification/pcr_power_trim_value_regs_tb.sv
// Purpose: Self-checking bench for the calibration and reset cause regs
// Assumes: Zero wait APB slave; fuse loader driven by the bench
// Notes: Each test is one task
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module pcr_power_trim_value_regs_tb;
    reg sys_clk = 1'b0;
    reg rstn = 1'b0;
    reg por_n = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0000_0000;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    reg fuse_load = 1'b0;
    reg [1:0] fuse_sel = 2'h0;
    reg [9:0] fuse_data = 10'h000;
    reg [5:0] reset_source_in = 6'h01;
    reg brownout_detect = 1'b0;
    reg interrupt_mask_view = 1'b0;
    wire [9:0] rc_osc_trim_out;
    wire [2:0] bandgap_trim_out;
    wire [2:0] regulator_trim_out;
    wire brownout_detector_enable;
    wire brownout_reset_enable;
    wire brownout_hysteresis;
    wire [5:0] brownout_level;
    wire brownout_reset_req;
    wire brownout_irq_req;
    wire usb_wakeup_enable;
    integer err_count = 0;
    integer n_compared = 0;
    integer i;
    integer m;
    reg [31:0] rd;
    reg [31:0] e;
    reg er;

    pcr_power_trim_value_regs dut (
        .sys_clk(sys_clk), .rstn(rstn), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fuse_load(fuse_load), .fuse_sel(fuse_sel),
        .fuse_data(fuse_data), .reset_source_in(reset_source_in),
        .brownout_detect(brownout_detect),
        .interrupt_mask_view(interrupt_mask_view),
        .rc_osc_trim_out(rc_osc_trim_out),
        .bandgap_trim_out(bandgap_trim_out),
        .regulator_trim_out(regulator_trim_out),
        .brownout_detector_enable(brownout_detector_enable),
        .brownout_reset_enable(brownout_reset_enable),
        .brownout_hysteresis(brownout_hysteresis),
        .brownout_level(brownout_level),
        .brownout_reset_req(brownout_reset_req),
        .brownout_irq_req(brownout_irq_req),
        .usb_wakeup_enable(usb_wakeup_enable)
    );

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
        begin
            @(posedge sys_clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            // Wait for the slave; only the watchdog ends a hang
            do begin
                @(posedge sys_clk);
            end while (pready !== 1'b1);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(negedge sys_clk);
        end
    endtask

    task rd_chk(input reg [11:0] a, input reg [31:0] x);
        begin
            apb(1'b0, a, 32'h0000_0000);
            `CHK(rd, x)
        end
    endtask

    task kw(input reg [11:0] a, input reg [23:0] d);
        begin
            apb(1'b1, a, 32'h5500_0000);
            apb(1'b1, a, {8'haa, d});
        end
    endtask

    task fz(input reg [1:0] s, input reg [9:0] d);
        begin
            @(posedge sys_clk);
            fuse_load <= 1'b1;
            fuse_sel <= s;
            fuse_data <= d;
            @(posedge sys_clk);
            fuse_load <= 1'b0;
            @(negedge sys_clk);
        end
    endtask

    task do_rst(input reg p, input reg [5:0] src);
        begin
            @(posedge sys_clk);
            reset_source_in <= src;
            rstn <= 1'b0;
            por_n <= !p;
            repeat (12) @(posedge sys_clk);
            rstn <= 1'b1;
            por_n <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
    endtask

    task t_key;
        begin
            apb(1'b1, 12'h0c8, 32'haa00_0005);
            rd_chk(12'h0c8, 32'h0000_0000);
            apb(1'b1, 12'h0c8, 32'h5500_0000);
            apb(1'b1, 12'h0c8, 32'h5500_0006);
            rd_chk(12'h0c8, 32'h0000_0000);
            kw(12'h0c8, 24'h00_0005);
            `CHK(regulator_trim_out, 3'h5)
            rd_chk(12'h0c8, 32'h0000_0005);
            kw(12'h0c0, 24'h00_03ff);
            `CHK(rc_osc_trim_out, 10'h3ff)
            $display("key test done");
        end
    endtask

    task t_fuse;
        begin
            fz(2'h1, 10'h003);
            `CHK(bandgap_trim_out, 3'h3)
            rd_chk(12'h0c4, 32'h0001_0003);
            fz(2'h1, 10'h006);
            `CHK(bandgap_trim_out, 3'h3)
            $display("fuse test done");
        end
    endtask

    task t_bod;
        begin
            fz(2'h3, 10'h26a);
            `CHK(brownout_level, 6'h2a)
            `CHK(brownout_hysteresis, 1'b1)
            rd_chk(12'h0d0, 32'h0001_026a);
            fz(2'h3, 10'h000);
            `CHK(brownout_level, 6'h2a)
            @(posedge sys_clk);
            brownout_detect <= 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
                kw(12'h0d0, {8'h01, 6'h00, i[1:0], 8'h6a});
                for (m = 0; m < 2; m = m + 1) begin
                    @(posedge sys_clk);
                    interrupt_mask_view <= m[0];
                    @(negedge sys_clk);
                    `CHK(brownout_detector_enable, i == 1 || i == 2)
                    `CHK(brownout_reset_req, i == 1)
                    `CHK(brownout_reset_enable, i == 1)
                    `CHK(brownout_irq_req, i == 2 && m == 1)
                end
            end
            @(posedge sys_clk);
            brownout_detect <= 1'b0;
            $display("brown-out test done");
        end
    endtask

    task t_cause;
        begin
            rd_chk(12'h140, 32'h0000_0001);
            rd_chk(12'h144, 32'h0000_0000);
            apb(1'b1, 12'h144, 32'h0000_0001);
            `CHK(usb_wakeup_enable, 1'b1)
            apb(1'b1, 12'h200, 32'h1234_5678);
            apb(1'b1, 12'h204, 32'h9abc_def0);
            for (i = 0; i < 6; i = i + 1) begin
                do_rst(1'b0, 6'h01 << i);
                e = (i == 5) ? 32'h0000_0100 : 32'h0000_0001 << i;
                rd_chk(12'h140, e);
                `CHK(rd, e)
            end
            `CHK(usb_wakeup_enable, 1'b0)
            rd_chk(12'h200, 32'h1234_5678);
            rd_chk(12'h204, 32'h9abc_def0);
            apb(1'b1, 12'h140, 32'hffff_ffff);
            rd_chk(12'h140, 32'h0000_0100);
            apb(1'b0, 12'h0fc, 32'h0000_0000);
            `CHK(er, 1'b1)
            do_rst(1'b1, 6'h01);
            rd_chk(12'h200, 32'h0000_0000);
            fz(2'h1, 10'h005);
            `CHK(bandgap_trim_out, 3'h5)
            $display("reset cause test done");
        end
    endtask

    task wrap_up;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    initial begin
        #500000;
        err_count = err_count + 1;
        $display("watchdog expired");
        wrap_up;
    end

    initial begin
        do_rst(1'b1, 6'h01);
        t_key;
        t_fuse;
        t_bod;
        t_cause;
        wrap_up;
    end
endmodule // pcr_power_trim_value_regs_tb
